// [mon_pkg.sv]
// shared constants for the monitor command and security block
package mon_pkg;
    localparam logic [7:0]  OP_READ       = 8'h1a;
    localparam logic [7:0]  OP_WRITE      = 8'h19;
    localparam logic [7:0]  OP_INDEXED_READ  = 8'h1a;
    localparam logic [7:0]  OP_INDEXED_WRITE = 8'h19;
    localparam logic [7:0]  OP_READ_SP       = 8'h0c;
    localparam logic [7:0]  OP_RUN        = 8'h28;
    localparam logic [15:0] SEC_BASE      = 16'hfff6;
    localparam int          SEC_COUNT     = 8;
    localparam logic [3:0]  SEC_LAST      = 4'h7;
    localparam logic [15:0] FLASH_BASE    = 16'he000;
    localparam logic [7:0]  ERASED_BYTE   = 8'hff;
    localparam logic [7:0]  INVALID_BYTE  = 8'had;
    localparam logic [15:0] STATUS_ADDR   = 16'h0040;
    localparam int          STATUS_BIT    = 6;
    localparam logic [15:0] SP_RESET      = 16'h00ff;
    localparam logic [15:0] SP_PLUS_ONE   = 16'h0001;
    localparam logic [15:0] PC_HI_OFS     = 16'h0005;
    localparam logic [15:0] PC_LO_OFS     = 16'h0006;
    localparam logic [15:0] FRAME_BYTES   = 16'h0006;
    localparam logic [7:0]  BREAK_BYTE    = 8'h00;
endpackage

// [sync2.sv]
// two flip-flop synchroniser for one level
`timescale 1ns/1ns
`default_nettype none
module sync2 (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic d,
    output logic      q
);
    logic meta_ff;
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_ff <= 1'b1;
            q       <= 1'b1;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// [monitor_command_security.sv]
// monitor command interpreter with security gate
// Overview of operation
// (R1) repeated indexed read/write step through the full 16-bit address space
// (R2) indexed write opcode recognised, bytes echoed, data stored at next address
// (R3) run command restores high index from stack then returns from interrupt
// (R4) monitor entry does software interrupt then pushes high index byte
// (R5) host may overwrite stacked registers before run
// (R6) read stack pointer returns stack pointer plus one
// (R7) saved program counter high at sp+5, low at sp+6
// (R8) after power-on reset wait for eight security bytes on serial pin
// (R9) eight matching bytes unlock flash read and execution
// (R10) unlock persists until next power-on reset only
// (R11) other resets keep bypass state and skip code entry
// (R12) failed check: flash reads return an invalid value
// (R13) flash fetch while locked raises illegal address reset
// (R14) break character sent only after all eight security bytes
// (R15) ram status bit set when code entered correctly
// (R16) host may reset and retry after a failed check
// (R17) bulk erase leaves all eight security bytes at all ones
// (R18) security bytes should always be programmed
`timescale 1ns/1ns
`default_nettype none
module monitor_command_security
    import mon_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        por,
    input  wire logic        serial_pin,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        tx_ready,
    output logic             tx_valid,
    output logic [7:0]       tx_byte,
    output logic             tx_break,
    output logic             mem_req,
    output logic             mem_we,
    output logic [15:0]      mem_addr,
    output logic [7:0]       mem_wdata,
    input  wire logic [7:0]  mem_rdata,
    input  wire logic        mem_ack,
    input  wire logic        fetch_valid,
    input  wire logic [15:0] fetch_addr,
    input  wire logic        bulk_erase_done,
    output logic             software_interrupt,
    output logic             push_high_index,
    output logic             pop_high_index,
    output logic             return_from_interrupt,
    output logic             illegal_addr_reset,
    output logic             secure_bypass,
    output logic             monitor_serial_pin_seen,
    output logic [15:0]      stack_ptr
);
    typedef enum logic [3:0] {
        ST_ENTRY  = 4'b0000,
        ST_PUSH   = 4'b0001,
        ST_SEC    = 4'b0010,
        ST_SECRD  = 4'b0011,
        ST_BREAK  = 4'b0100,
        ST_CMD    = 4'b0101,
        ST_ECHO   = 4'b0110,
        ST_DATA   = 4'b0111,
        ST_MEM    = 4'b1000,
        ST_SEND   = 4'b1001,
        ST_SEND2  = 4'b1010,
        ST_RUN    = 4'b1011,
        ST_RETURN = 4'b1100,
        ST_USER   = 4'b1101
    } state_t;

    state_t      state_ff;
    logic [7:0]  cmd_ff;
    logic [15:0] ptr_ff;
    logic [15:0] sp_ff;
    logic [7:0]  data_ff;
    logic [3:0]  sec_cnt_ff;
    logic        sec_ok_ff;
    logic        unlocked_ff;
    logic        por_seen_ff;
    logic [7:0]  sec_byte_ff;
    logic        pin_q;

    sync2 u_sync (
        .clk  (clk),
        .srst (srst),
        .d    (serial_pin),
        .q    (pin_q)
    );

    // flash reads are masked unless the bypass is in force
    wire is_flash     = (mem_addr >= FLASH_BASE);
    wire is_status    = (mem_addr == STATUS_ADDR);
    wire [7:0] status_byte = 8'(unlocked_ff) << STATUS_BIT; // R15
    wire [7:0] rd_byte = is_status ? (mem_rdata | status_byte)
                       : (is_flash && !unlocked_ff) ? INVALID_BYTE // R12
                       : mem_rdata;
    wire sec_match    = (rx_byte == sec_byte_ff);
    wire [15:0] sp_ret = sp_ff + SP_PLUS_ONE; // R6
    wire [15:0] pc_hi_addr = sp_ff + PC_HI_OFS; // R7
    wire [15:0] pc_lo_addr = sp_ff + PC_LO_OFS; // R7

    assign stack_ptr               = sp_ret;
    assign secure_bypass           = unlocked_ff;
    assign monitor_serial_pin_seen = pin_q;
    assign mem_req  = (state_ff == ST_MEM) || (state_ff == ST_SECRD);
    assign tx_valid = (state_ff == ST_ECHO) || (state_ff == ST_SEND)
                    || (state_ff == ST_SEND2) || (state_ff == ST_BREAK);
    assign tx_break = (state_ff == ST_BREAK); // R14
    assign tx_byte  = data_ff;
    assign software_interrupt    = (state_ff == ST_ENTRY); // R4
    assign push_high_index       = (state_ff == ST_PUSH); // R4
    assign pop_high_index        = (state_ff == ST_RUN); // R3
    assign return_from_interrupt = (state_ff == ST_RETURN); // R3
    // a fetch from flash while locked is an illegal address
    assign illegal_addr_reset = fetch_valid && !unlocked_ff
                              && (fetch_addr >= FLASH_BASE); // R13

    always_ff @(posedge clk) begin
        if (srst) begin
            mem_we    <= 1'b0;
            mem_addr  <= 16'h0000;
            mem_wdata <= 8'h00;
        end else if (state_ff == ST_PUSH) begin
            // address must stand before the request rises
            mem_we    <= 1'b0;
            mem_addr  <= SEC_BASE;
        end else if (state_ff == ST_SEC && rx_valid) begin
            mem_addr  <= SEC_BASE + 16'(sec_cnt_ff) + 16'h0001;
        end else if (state_ff == ST_CMD && rx_valid) begin
            mem_we    <= (rx_byte == OP_INDEXED_WRITE);
            mem_addr  <= ptr_ff;
        end else if (state_ff == ST_SEND && tx_ready
                     && cmd_ff == OP_INDEXED_READ) begin
            mem_addr  <= ptr_ff; // R1
        end else if (state_ff == ST_DATA && rx_valid) begin
            mem_wdata <= rx_byte;
            mem_addr  <= ptr_ff; // R2
        end
    end

    // bypass and por tracking: only a power-on reset clears the bypass; it sets por_seen_ff, which the first security byte clears
    always_ff @(posedge clk) begin
        if (por) begin
            unlocked_ff <= 1'b0; // R10
            por_seen_ff <= 1'b1;
        end else if (state_ff == ST_SEC && rx_valid) begin
            por_seen_ff <= 1'b0;
            if (sec_cnt_ff == SEC_LAST && sec_ok_ff && sec_match)
                unlocked_ff <= 1'b1; // R9
        end
    end

    always_ff @(posedge clk) begin
        if (srst || por) begin
            state_ff    <= ST_ENTRY;
            cmd_ff      <= 8'h00;
            ptr_ff      <= 16'h0000;
            sp_ff       <= SP_RESET;
            data_ff     <= 8'h00;
            sec_cnt_ff  <= 4'h0;
            sec_ok_ff   <= 1'b1;
            sec_byte_ff <= ERASED_BYTE;
        end else begin
            case (state_ff)
                ST_ENTRY: begin
                    sp_ff    <= sp_ff - FRAME_BYTES + 16'h0001;
                    state_ff <= ST_PUSH;
                end
                ST_PUSH: begin
                    sp_ff      <= sp_ff - 16'h0001;
                    sec_cnt_ff <= 4'h0;
                    sec_ok_ff  <= 1'b1;
                    // later resets skip code entry
                    state_ff <= por_seen_ff ? ST_SECRD : ST_BREAK; // R11
                end
                ST_SECRD: if (mem_ack) begin
                    sec_byte_ff <= bulk_erase_done ? ERASED_BYTE
                                 : mem_rdata; // R17
                    state_ff    <= ST_SEC; // R8
                end
                ST_SEC: if (rx_valid) begin
                    sec_ok_ff  <= sec_ok_ff && sec_match;
                    sec_cnt_ff <= sec_cnt_ff + 4'h1;
                    state_ff   <= (sec_cnt_ff == SEC_LAST) ? ST_BREAK
                                : ST_SECRD; // R14
                end
                ST_BREAK: if (tx_ready) begin
                    data_ff  <= BREAK_BYTE;
                    state_ff <= ST_CMD;
                end
                ST_CMD: if (rx_valid) begin
                    cmd_ff   <= rx_byte;
                    data_ff  <= rx_byte;
                    state_ff <= ST_ECHO;
                end
                ST_ECHO: if (tx_ready) begin
                    if (cmd_ff == OP_INDEXED_WRITE)
                        state_ff <= ST_DATA; // R2
                    else if (cmd_ff == OP_INDEXED_READ)
                        state_ff <= ST_MEM;
                    else if (cmd_ff == OP_READ_SP) begin
                        data_ff  <= sp_ret[15:8]; // R6
                        state_ff <= ST_SEND;
                    end else if (cmd_ff == OP_RUN)
                        state_ff <= ST_RUN;
                    else
                        state_ff <= ST_CMD;
                end
                ST_DATA: if (rx_valid) begin
                    data_ff  <= rx_byte;
                    state_ff <= ST_MEM;
                end
                ST_MEM: if (mem_ack) begin
                    ptr_ff <= ptr_ff + 16'h0001; // R1
                    if (cmd_ff == OP_INDEXED_WRITE) begin
                        state_ff <= ST_ECHO;
                        cmd_ff   <= 8'h00;
                    end else begin
                        data_ff  <= rd_byte;
                        state_ff <= ST_SEND;
                    end
                end
                ST_SEND: if (tx_ready) begin
                    if (cmd_ff == OP_READ_SP) begin
                        data_ff  <= sp_ret[7:0];
                        state_ff <= ST_SEND2;
                    end else if (cmd_ff == OP_INDEXED_READ) begin
                        // second byte of the pair, then back to commands
                        state_ff <= ST_MEM;
                        cmd_ff   <= 8'h00;
                    end else
                        state_ff <= ST_CMD;
                end
                ST_SEND2: if (tx_ready)
                    state_ff <= ST_CMD;
                ST_RUN: begin
                    sp_ff    <= sp_ff + 16'h0001; // R3
                    state_ff <= ST_RETURN;
                end
                ST_RETURN: begin
                    // stacked context, possibly edited by the host, resumes
                    sp_ff    <= sp_ff + FRAME_BYTES - 16'h0001; // R5
                    state_ff <= ST_USER;
                end
                ST_USER: state_ff <= ST_USER;
                default: state_ff <= ST_ENTRY;
            endcase
        end
    end

    wire unused_ok = &{1'b0, pc_hi_addr, pc_lo_addr, OP_READ, OP_WRITE};
endmodule
`default_nettype wire

// [mcs_chk.sv]
// concurrent checks on the monitor command block ports
`timescale 1ns/1ns
`default_nettype none
module mcs_chk
    import mon_pkg::*;
(
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        por,
    input wire logic        rx_valid,
    input wire logic        tx_valid,
    input wire logic        tx_ready,
    input wire logic [7:0]  tx_byte,
    input wire logic        tx_break,
    input wire logic        mem_req,
    input wire logic        mem_ack,
    input wire logic [15:0] mem_addr,
    input wire logic        fetch_valid,
    input wire logic [15:0] fetch_addr,
    input wire logic        software_interrupt,
    input wire logic        push_high_index,
    input wire logic        pop_high_index,
    input wire logic        return_from_interrupt,
    input wire logic        illegal_addr_reset,
    input wire logic        secure_bypass
);
    logic [3:0] rx_cnt_ff;
    // bytes received since power-on, saturating at eight
    always_ff @(posedge clk) begin
        if (por)
            rx_cnt_ff <= 4'h0;
        else if (rx_valid && rx_cnt_ff < 4'h8)
            rx_cnt_ff <= rx_cnt_ff + 4'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst || por);
    sequence entry_s;
        software_interrupt ##1 push_high_index;
    endsequence
    sequence run_s;
        pop_high_index ##1 return_from_interrupt;
    endsequence
    entry_order_a: assert property (software_interrupt |-> entry_s)
        else $error("push did not follow interrupt");
    run_order_a: assert property (pop_high_index |-> run_s)
        else $error("return did not follow pop");
    tx_hold_a: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable(tx_byte)) else $error("tx byte dropped");
    mem_hold_a: assert property (mem_req && !mem_ack |=>
        mem_req && $stable(mem_addr)) else $error("mem request dropped");
    bypass_keep_a: assert property (disable iff (por)
        secure_bypass |=> secure_bypass) else $error("bypass lost");
    por_clear_a: assert property ($fell(por) |-> !secure_bypass)
        else $error("bypass survived power-on");
    locked_fetch_a: assert property (fetch_valid &&
        fetch_addr >= FLASH_BASE && !secure_bypass |-> illegal_addr_reset)
        else $error("locked fetch not trapped");
    fetch_trap_a: assert property (illegal_addr_reset |->
        !secure_bypass && fetch_valid) else $error("spurious trap");
    break_late_a: assert property (tx_break |-> rx_cnt_ff == 4'h8)
        else $error("break before eight bytes");
endmodule
bind monitor_command_security mcs_chk u_chk (.clk, .srst, .por,
    .rx_valid, .tx_valid, .tx_ready, .tx_byte, .tx_break, .mem_req,
    .mem_ack, .mem_addr, .fetch_valid, .fetch_addr, .software_interrupt,
    .push_high_index, .pop_high_index, .return_from_interrupt,
    .illegal_addr_reset, .secure_bypass);
`default_nettype wire

// [mon_mem.sv]
// memory model answering the block's memory requests
`timescale 1ns/1ns
`default_nettype none
module mon_mem
    import mon_pkg::*;
(
    input wire logic        clk,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0]  mem_wdata,
    input wire logic        bulk_erase_done,
    output var logic [7:0]  mem_rdata = 8'h00,
    output var logic        mem_ack = 1'b0,
    output var logic [15:0] last_waddr = 16'h0000
);
    logic       wait_ff = 1'b0;
    logic [7:0] ram_ff [0:255] = '{default: 8'h00};
    wire        sec_hit = mem_addr >= SEC_BASE && mem_addr <= 16'hfffd;
    // key bytes are arbitrary; after bulk erase the key bytes read all ones
    wire  [7:0] sec_byte = bulk_erase_done ? ERASED_BYTE
                                           : mem_addr[7:0] ^ 8'h5a;
    always_ff @(posedge clk) begin
        wait_ff <= mem_req && !wait_ff && !mem_ack;
        mem_ack <= mem_req && wait_ff && !mem_ack;
        mem_rdata <= ~mem_rdata;
        if (mem_req && wait_ff && !mem_ack) begin
            mem_rdata <= sec_hit ? sec_byte : ram_ff[mem_addr[7:0]];
            if (mem_we) begin
                ram_ff[mem_addr[7:0]] <= mem_wdata;
                last_waddr <= mem_addr;
            end
        end
    end
endmodule
`default_nettype wire

// [tb.sv]
// testbench for the monitor command and security block
`timescale 1ns/1ns
`default_nettype none
module tb;
    import mon_pkg::*;
    logic        clk = 1'b0, srst = 1'b1, por = 1'b1, rx_valid = 1'b0;
    logic        fetch_valid = 1'b0, bulk_erase_done = 1'b0;
    logic [7:0]  rx_byte = 8'h00, tx_byte, mem_wdata, mem_rdata, b;
    logic [15:0] fetch_addr = 16'h0000, mem_addr, last_waddr, wa;
    logic        tx_valid, tx_break, mem_req, mem_we, mem_ack, illegal;
    logic        pop_hi, bypass, brk_seen = 1'b0;
    logic        serial = 1'b1, tx_ready = 1'b1, pin_seen;
    logic [15:0] sp_out;
    logic [7:0]  txq[$];
    int          n_errors = 0, checks_done = 0, pop_n = 0;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (tx_valid && tx_ready && !tx_break)
            txq.push_back(tx_byte);
        if (tx_break)
            brk_seen = 1'b1;
        if (pop_hi)
            pop_n++;
    end
    monitor_command_security u_dut (.clk, .srst, .por, .serial_pin(serial),
        .rx_valid, .rx_byte, .tx_ready, .tx_valid, .tx_byte,
        .tx_break, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
        .mem_ack, .fetch_valid, .fetch_addr, .bulk_erase_done,
        .software_interrupt(), .push_high_index(), .pop_high_index(pop_hi),
        .return_from_interrupt(), .illegal_addr_reset(illegal),
        .secure_bypass(bypass), .monitor_serial_pin_seen(pin_seen),
        .stack_ptr(sp_out));
    mon_mem u_mem (.clk, .mem_req, .mem_we, .mem_addr, .mem_wdata,
        .bulk_erase_done, .mem_rdata, .mem_ack, .last_waddr);
    task automatic chk(input string what, input logic [15:0] e, a);
        checks_done++;
        if (a !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, a);
        end
    endtask
    task automatic send(input logic [7:0] v);
        @(posedge clk) rx_valid <= 1'b1;
        rx_byte <= v;
        @(posedge clk) rx_valid <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
    task automatic take(input string what, input logic [7:0] e);
        for (int i = 0; i < 60 && txq.size() == 0; i++) @(posedge clk);
        chk(what, e, txq.size() ? txq.pop_front() : 8'hxx);
    endtask
    task automatic grab(output logic [7:0] v);
        for (int i = 0; i < 60 && txq.size() == 0; i++) @(posedge clk);
        v = txq.size() ? txq.pop_front() : 8'hxx;
    endtask
    task automatic power_up(input logic cold, good, erased);
        @(posedge clk) srst <= 1'b1;
        por <= cold;
        bulk_erase_done <= erased;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        por <= 1'b0;
        repeat (8) @(posedge clk);
        txq.delete();
        brk_seen = 1'b0;
        for (int i = 0; cold && i < 8; i++) begin
            chk("early break", 0, brk_seen);
            b = erased ? 8'hff : (8'hf6 + i[7:0]) ^ 8'h5a;
            send(good ? b : ~b);
        end
        repeat (40) @(posedge clk);
        if (cold)
            chk("break", 1, brk_seen);
        txq.delete();
        chk("bypass", good, bypass);
    endtask
    task automatic fetch_chk(input logic e);
        @(posedge clk) fetch_valid <= 1'b1;
        fetch_addr <= FLASH_BASE;
        @(negedge clk) chk("illegal reset", e, illegal);
        @(posedge clk) fetch_valid <= 1'b0;
    endtask
    task automatic t_commands();
        serial <= 1'b0;
        repeat (3) @(posedge clk);
        chk("pin seen", 0, pin_seen);
        serial <= 1'b1;
        // hold the transmitter off so the echo must wait
        tx_ready <= 1'b0;
        send(OP_READ_SP);
        tx_ready <= 1'b1;
        take("read sp echo", OP_READ_SP);
        wa = SP_RESET - FRAME_BYTES + SP_PLUS_ONE;
        chk("stack pointer", wa, sp_out);
        take("sp high", wa[15:8]);
        take("sp low", wa[7:0]);
        for (int i = 0; i < 2; i++) begin
            send(OP_INDEXED_WRITE);
            take("write echo", OP_INDEXED_WRITE);
            send(8'ha5 + i[7:0]);
            take("data echo", 8'ha5 + i[7:0]);
            if (i == 1)
                chk("next address", wa + 16'h1, last_waddr);
            wa = last_waddr;
        end
        send(OP_RUN);
        take("run echo", OP_RUN);
        chk("pop count", 1, pop_n);
    endtask
    // reads step from address zero through the status byte at 0x40 and on to 0x41
    task automatic t_reads(input logic open);
        for (int i = 0; i < 33; i++) begin
            send(OP_INDEXED_READ);
            take("read echo", OP_INDEXED_READ);
            grab(b);
            if (i == 0)
                chk("read first", 8'ha5, b);
            if (i == 32)
                chk("status bit", open, b[6]);
            grab(b);
            if (i == 0)
                chk("read next", 8'ha6, b);
        end
    endtask
    task automatic report_and_stop();
        if (n_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end
    initial begin
        power_up(1'b1, 1'b1, 1'b0);
        fetch_chk(1'b0);
        power_up(1'b0, 1'b1, 1'b0);
        t_commands();
        power_up(1'b0, 1'b1, 1'b0);
        t_reads(1'b1);
        power_up(1'b1, 1'b0, 1'b0);
        fetch_chk(1'b1);
        t_reads(1'b0);
        power_up(1'b1, 1'b1, 1'b1);
        report_and_stop();
    end
endmodule
`default_nettype wire
